// *** design/spi_mem_device.sv ***
// serial nonvolatile memory slave, 2048 x 8
// How it works
// - chip select high: standby, output released
// - master drops select before each command
// - sample input on rise, drive on fall
// - static operation, clock may stop anytime
// - master keeps input at valid level
// - output driven only for read data and status read data
// - protect pin blocks status writes if enabled
// - hold low freezes clock and select
// - master moves hold only while clock low
// - byte stored at its eighth bit
// - array holds 2048 bytes
// - modes zero and three behave alike
// - two address bytes follow read, write
// - write disable command clears write latch
// - block protect covers quarter, half, all
// - upper five address bits ignored
// - first byte command, msb first throughout
// - unknown command ignored until next select
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module spi_mem_device #(
	parameter int DEPTH = spi_mem_pkg::MEM_DEPTH
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	spi_link_if.device       link,
	output logic [7:0]       o_status,
	output logic             o_active
);
	// =====================================================
	// pin synchronisers
	logic [4:0]              pin_s1_r;
	logic [4:0]              pin_s2_r;
	logic                    sck_d_r;
	logic                    cs_n_s;
	logic                    sck_s;
	logic                    si_s;
	logic                    hold_s;
	logic                    wp_n_s;
	logic                    rise;
	logic                    fall;
	logic                    sel;

	// two flops on every pin from the link
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			pin_s1_r <= 5'h13;
			pin_s2_r <= 5'h13;
		end
		else
		begin
			pin_s1_r <= {link.cs_n, link.sck, link.si, link.hold_n, link.wp_n};
			pin_s2_r <= pin_s1_r;
		end
	end

	assign {cs_n_s, sck_s, si_s, hold_s, wp_n_s} = pin_s2_r;
	assign sel = ~cs_n_s;

	// clock edge finder, gated by hold
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			sck_d_r <= 1'b0;
		else
			sck_d_r <= sck_s;
	end

	assign rise = hold_s & sel & sck_s & ~sck_d_r;
	assign fall = hold_s & sel & ~sck_s & sck_d_r;

	// =====================================================
	// command engine
	spi_mem_pkg::dev_state_t state_r;
	logic                    active_r;
	logic [2:0]              bit_cnt_r;
	logic [6:0]              shift_r;
	logic [10:0]             addr_r;
	logic                    addr_hi_r;
	logic                    is_read_r;
	logic                    wel_r;
	logic [7:0]              sr_r;
	logic [7:0]              status_v;
	logic                    byte_done;
	logic [7:0]              rx_byte;
	logic [10:0]             addr_in;
	logic [10:0]             rd_addr;
	logic                    blocked;
	logic                    sr_locked;
	logic                    addr_last;

	assign byte_done = rise & (bit_cnt_r == 3'h7);
	assign rx_byte   = {shift_r, si_s};
	assign addr_in   = {addr_r[9:0], si_s};
	assign addr_last = (state_r == spi_mem_pkg::S_ADDR) & addr_hi_r;
	assign rd_addr   = addr_last ? addr_in : addr_r;
	assign sr_locked = sr_r[spi_mem_pkg::SR_PPE_BIT] & ~wp_n_s;

	// block protect decode
	always_comb
	begin
		unique case (sr_r[spi_mem_pkg::SR_BP_HI:spi_mem_pkg::SR_BP_LO])
			2'h0: blocked = 1'b0;
			2'h1: blocked = (addr_r[10:9] == 2'h3);
			2'h2: blocked = addr_r[10];
			2'h3: blocked = 1'b1;
		endcase
	end

	// select tracking, frozen while held
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			active_r <= 1'b0;
		else if (hold_s)
			active_r <= sel;
	end

	// state, bit count and address
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			state_r   <= spi_mem_pkg::S_IDLE;
			bit_cnt_r <= 3'h0;
			shift_r   <= 7'h00;
			addr_r    <= 11'h000;
			addr_hi_r <= 1'b0;
			is_read_r <= 1'b0;
		end
		else if (hold_s)
		begin
			if (!sel)
				state_r <= spi_mem_pkg::S_IDLE;
			else if (!active_r)
			begin
				state_r   <= spi_mem_pkg::S_CMD;
				bit_cnt_r <= 3'h0;
			end
			else if (rise)
			begin
				bit_cnt_r <= bit_cnt_r + 3'h1;
				shift_r   <= rx_byte[6:0];
				unique case (state_r)
					spi_mem_pkg::S_CMD:
						if (byte_done)
						begin
							addr_hi_r <= 1'b0;
							is_read_r <= (rx_byte == spi_mem_pkg::CMD_READ);
							if (rx_byte == spi_mem_pkg::CMD_READ
								|| rx_byte == spi_mem_pkg::CMD_WRITE)
								state_r <= spi_mem_pkg::S_ADDR;
							else if (rx_byte == spi_mem_pkg::CMD_RD_STAT)
								state_r <= spi_mem_pkg::S_RDSTAT;
							else if (rx_byte == spi_mem_pkg::CMD_WR_STAT)
								state_r <= spi_mem_pkg::S_WRSTAT;
							else
								state_r <= spi_mem_pkg::S_IDLE;
						end
					spi_mem_pkg::S_ADDR:
					begin
						addr_r <= addr_in;
						if (byte_done)
						begin
							addr_hi_r <= 1'b1;
							if (addr_hi_r && is_read_r)
							begin
								addr_r  <= addr_in + 11'h001;
								state_r <= spi_mem_pkg::S_READ;
							end
							else if (addr_hi_r)
								state_r <= spi_mem_pkg::S_WRITE;
						end
					end
					spi_mem_pkg::S_WRITE,
					spi_mem_pkg::S_READ:
						if (byte_done)
							addr_r <= addr_r + 11'h001;
					// stay here so deselect clears the latch;
					// address flag marks first status byte taken
					spi_mem_pkg::S_WRSTAT:
						if (byte_done)
							addr_hi_r <= 1'b1;
					spi_mem_pkg::S_RDSTAT,
					spi_mem_pkg::S_IDLE:
						;
				endcase
			end
		end
	end

	// =====================================================
	// array, written at each eighth bit
	logic [7:0]              mem [0:DEPTH-1];

	always_ff @(posedge i_ref_clk)
	begin
		if (byte_done && state_r == spi_mem_pkg::S_WRITE && wel_r && !blocked)
			mem[addr_r] <= rx_byte;
	end

	// =====================================================
	// write latch and status byte
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			wel_r <= 1'b0;
			sr_r  <= spi_mem_pkg::SR_RESET;
		end
		else if (byte_done && state_r == spi_mem_pkg::S_CMD)
		begin
			if (rx_byte == spi_mem_pkg::CMD_WREN)
				wel_r <= 1'b1;
			else if (rx_byte == spi_mem_pkg::write_disable_command)
				wel_r <= 1'b0;
		end
		else if (byte_done && state_r == spi_mem_pkg::S_WRSTAT && wel_r && !sr_locked
			&& !addr_hi_r)
			sr_r <= rx_byte & spi_mem_pkg::SR_WMASK;
		else if (hold_s && !sel && active_r
			&& (state_r == spi_mem_pkg::S_WRITE || state_r == spi_mem_pkg::S_WRSTAT))
			wel_r <= 1'b0;
	end

	// status view with live write latch
	always_comb
	begin
		status_v = sr_r;
		status_v[spi_mem_pkg::SR_WEL_BIT] = wel_r;
	end

	// =====================================================
	// serial output
	logic [7:0]              tx_r;
	logic                    so_r;
	logic                    oe_r;
	logic                    rd_state;

	assign rd_state = (state_r == spi_mem_pkg::S_READ)
		| (state_r == spi_mem_pkg::S_RDSTAT);

	// load on byte boundary, shift on falling clock
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			tx_r <= 8'h00;
			so_r <= 1'b0;
			oe_r <= 1'b0;
		end
		else if (hold_s && !sel)
			oe_r <= 1'b0;
		else if (byte_done && ((addr_last && is_read_r) || state_r == spi_mem_pkg::S_READ))
			tx_r <= mem[rd_addr];
		else if (byte_done && ((state_r == spi_mem_pkg::S_CMD
			&& rx_byte == spi_mem_pkg::CMD_RD_STAT) || state_r == spi_mem_pkg::S_RDSTAT))
			tx_r <= status_v;
		else if (fall && rd_state)
		begin
			so_r <= tx_r[7];
			tx_r <= {tx_r[6:0], 1'b0};
			oe_r <= 1'b1;
		end
	end

	assign link.so    = so_r;
	assign link.so_oe = oe_r & hold_s & sel;
	assign o_status   = status_v;
	assign o_active   = active_r;

endmodule // spi_mem_device
`default_nettype wire

// *** include/spi_mem_pkg.sv ***
// shared constants for the serial memory link, both ends
package spi_mem_pkg;

	// =====================================================
	// memory array
	localparam int          MEM_DEPTH    = 2048;
	localparam int          MEM_AW       = 11;

	// =====================================================
	// command bytes
	localparam logic [7:0]  CMD_WREN     = 8'h06;
	localparam logic [7:0]  write_disable_command = 8'h04;
	localparam logic [7:0]  CMD_RD_STAT  = 8'h05;
	localparam logic [7:0]  CMD_WR_STAT  = 8'h01;
	localparam logic [7:0]  CMD_READ     = 8'h03;
	localparam logic [7:0]  CMD_WRITE    = 8'h02;

	// =====================================================
	// status byte layout
	localparam int          SR_PPE_BIT   = 7;
	localparam int          SR_BP_HI     = 3;
	localparam int          SR_BP_LO     = 2;
	localparam int          SR_WEL_BIT   = 1;
	localparam logic [7:0]  SR_WMASK     = 8'h8c;
	localparam logic [7:0]  SR_RESET     = 8'h00;

	// =====================================================
	// controller registers (byte offsets)
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_TX       = 8'h04;
	localparam logic [7:0]  REG_STAT     = 8'h08;
	localparam logic [7:0]  REG_RX       = 8'h0c;
	localparam int          CTRL_CS_BIT  = 0;
	localparam int          CTRL_HOLD_BIT = 1;
	localparam int          CTRL_WP_BIT  = 2;
	localparam int          CTRL_CPOL_BIT = 3;
	localparam logic [3:0]  CTRL_RESET   = 4'h6;

	// =====================================================
	// timing
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          SCK_PERIOD_NS = 160;
	localparam int          SCK_HALF_CYC  = (SCK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
		/ (2 * CLK_PERIOD_NS);

	// =====================================================
	// state types
	typedef enum logic [6:0] {
		S_IDLE   = 7'h01,
		S_CMD    = 7'h02,
		S_ADDR   = 7'h04,
		S_WRITE  = 7'h08,
		S_READ   = 7'h10,
		S_RDSTAT = 7'h20,
		S_WRSTAT = 7'h40
	} dev_state_t;

	typedef enum logic [1:0] {
		E_IDLE = 2'h1,
		E_RUN  = 2'h2
	} eng_state_t;

endpackage

// *** include/spi_link_if.sv ***
// serial link between the memory and its controller
`timescale 1ns/10ps
`default_nettype none
interface spi_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic hold_n;
	logic wp_n;
	logic so;
	logic so_oe;
	logic so_line;

	// released output line reads high
	assign so_line = so_oe ? so : 1'b1;

	modport device (input cs_n, input sck, input si, input hold_n, input wp_n,
		output so, output so_oe);
	modport master (output cs_n, output sck, output si, output hold_n, output wp_n,
		input so_line);
endinterface
`default_nettype wire

// *** design/spi_mem_master.sv ***
// serial memory controller reached over apb
`timescale 1ns/10ps
`default_nettype none
module spi_mem_master #(
	parameter int DIV_HALF  = spi_mem_pkg::SCK_HALF_CYC,
	parameter int BUF_DEPTH = 2,
	parameter int BUF_WIDTH = 8
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	spi_link_if.master       link
);
	localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

	// =====================================================
	// apb decode
	logic [3:0]              ctrl_r;
	logic                    acc;
	logic                    tx_req;
	logic                    tx_go;
	logic                    rd_rx;
	logic                    mapped;
	logic                    busy;
	logic                    push_r;
	logic [PW:0]             cnt_r;

	assign acc    = i_psel & i_penable;
	assign mapped = (i_paddr == spi_mem_pkg::REG_CTRL) | (i_paddr == spi_mem_pkg::REG_TX)
		| (i_paddr == spi_mem_pkg::REG_STAT) | (i_paddr == spi_mem_pkg::REG_RX);
	assign tx_req = acc & i_pwrite & (i_paddr == spi_mem_pkg::REG_TX);
	assign rd_rx  = acc & ~i_pwrite & (i_paddr == spi_mem_pkg::REG_RX);
	// byte starts only with room for its answer
	assign tx_go  = tx_req & ~busy & ~push_r & (cnt_r < (PW + 1)'(BUF_DEPTH));
	assign o_pready  = ~(tx_req & ~tx_go);
	assign o_pslverr = acc & ~mapped;

	// control register
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			ctrl_r <= spi_mem_pkg::CTRL_RESET;
		else if (acc && i_pwrite && i_paddr == spi_mem_pkg::REG_CTRL)
			ctrl_r <= i_pwdata[3:0];
	end

	// =====================================================
	// receive buffer
	logic [BUF_WIDTH-1:0]    buf_mem [0:BUF_DEPTH-1];
	logic [PW-1:0]           wp_r;
	logic [PW-1:0]           rp_r;
	logic                    head_ok_r;
	logic                    pop;
	logic [7:0]              rxs_r;

	assign pop = rd_rx & head_ok_r;

	always_ff @(posedge i_ref_clk)
	begin
		if (push_r)
			buf_mem[wp_r] <= rxs_r;
	end

	// pointers and fill count
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push_r)
				wp_r <= (wp_r == PW'(BUF_DEPTH - 1)) ? '0 : wp_r + PW'(1);
			if (pop)
				rp_r <= (rp_r == PW'(BUF_DEPTH - 1)) ? '0 : rp_r + PW'(1);
			cnt_r <= cnt_r + (PW + 1)'(push_r) - (PW + 1)'(pop);
		end
	end

	// read data captured in setup cycle
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			o_prdata  <= 32'h0000_0000;
			head_ok_r <= 1'b0;
		end
		else if (i_psel && !i_penable && !i_pwrite)
		begin
			head_ok_r <= (i_paddr == spi_mem_pkg::REG_RX) && (cnt_r != '0);
			unique case (i_paddr)
				spi_mem_pkg::REG_CTRL: o_prdata <= {28'h0, ctrl_r};
				spi_mem_pkg::REG_STAT: o_prdata <= {29'h0,
					cnt_r == (PW + 1)'(BUF_DEPTH), cnt_r != '0, busy};
				spi_mem_pkg::REG_RX:   o_prdata <= (cnt_r != '0)
					? {{(32 - BUF_WIDTH){1'b0}}, buf_mem[rp_r]} : 32'h0;
				default:               o_prdata <= 32'h0000_0000;
			endcase
		end
	end

	// =====================================================
	// byte engine, sck from divider
	spi_mem_pkg::eng_state_t eng_r;
	logic [15:0]             div_r;
	logic                    tick;
	logic                    sck_r;
	logic                    si_r;
	logic [7:0]              txs_r;
	logic [3:0]              bits_r;
	logic [1:0]              so_s_r;
	logic                    hold_r;

	assign busy = (eng_r == spi_mem_pkg::E_RUN);
	assign tick = busy & (div_r == 16'(DIV_HALF - 1));

	// returned data through two flops
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			so_s_r <= 2'h3;
		else
			so_s_r <= {so_s_r[0], link.so_line};
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			div_r <= 16'h0000;
		else if (!busy || tick)
			div_r <= 16'h0000;
		else
			div_r <= div_r + 16'h0001;
	end

	// clock, data and bit count
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			eng_r  <= spi_mem_pkg::E_IDLE;
			sck_r  <= 1'b0;
			si_r   <= 1'b0;
			txs_r  <= 8'h00;
			rxs_r  <= 8'h00;
			bits_r <= 4'h0;
			push_r <= 1'b0;
		end
		else
		begin
			push_r <= 1'b0;
			unique case (eng_r)
				spi_mem_pkg::E_IDLE:
					if (tx_go)
					begin
						eng_r  <= spi_mem_pkg::E_RUN;
						txs_r  <= i_pwdata[7:0];
						si_r   <= i_pwdata[7];
						sck_r  <= 1'b0;
						bits_r <= 4'h0;
					end
					else
						sck_r <= ctrl_r[spi_mem_pkg::CTRL_CPOL_BIT];
				spi_mem_pkg::E_RUN:
					if (tick && !sck_r)
					begin
						sck_r  <= 1'b1;
						rxs_r  <= {rxs_r[6:0], so_s_r[1]};
						bits_r <= bits_r + 4'h1;
						if (bits_r == 4'h7 && ctrl_r[spi_mem_pkg::CTRL_CPOL_BIT])
						begin
							eng_r  <= spi_mem_pkg::E_IDLE;
							push_r <= 1'b1;
						end
					end
					else if (tick)
					begin
						sck_r <= 1'b0;
						if (bits_r == 4'h8)
						begin
							eng_r  <= spi_mem_pkg::E_IDLE;
							push_r <= 1'b1;
						end
						else
						begin
							txs_r <= {txs_r[6:0], 1'b0};
							si_r  <= txs_r[6];
						end
					end
			endcase
		end
	end

	// hold level moves only while clock low and not rising
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			hold_r <= 1'b1;
		else if (!sck_r && !tick)
			hold_r <= ctrl_r[spi_mem_pkg::CTRL_HOLD_BIT];
	end

	assign link.cs_n   = ~ctrl_r[spi_mem_pkg::CTRL_CS_BIT];
	assign link.sck    = sck_r;
	assign link.si     = si_r;
	assign link.hold_n = hold_r;
	assign link.wp_n   = ctrl_r[spi_mem_pkg::CTRL_WP_BIT];

endmodule // spi_mem_master
`default_nettype wire

// *** bench/spi_link_chk.sv ***
// checker for the serial link between controller and memory
`timescale 1ns/10ps
`default_nettype none
module spi_link_chk (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic so,
	input wire logic so_oe,
	input wire logic so_line
);
	logic       sck_d_r;
	logic [3:0] fall_cnt_r;

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	// ==========
	// serial clock delayed one cycle
	always_ff @(posedge i_ref_clk)
		sck_d_r <= sck;

	// cycles since the last serial clock fall
	always_ff @(posedge i_ref_clk)
		if (i_rst)
			fall_cnt_r <= 4'hf;
		else if (sck_d_r && !sck)
			fall_cnt_r <= 4'h0;
		else if (fall_cnt_r != 4'hf)
			fall_cnt_r <= fall_cnt_r + 4'h1;

	// ==========
	// assertions
	property p_desel_quiet;
		cs_n [*4] |-> !so_oe;
	endproperty
	a_desel_quiet: assert property (p_desel_quiet) else $error("so driven deselected");
	property p_hold_quiet;
		!hold_n [*4] |-> !so_oe;
	endproperty
	a_hold_quiet: assert property (p_hold_quiet) else $error("so driven in hold");
	property p_oe_sel;
		so_oe |-> !$past(cs_n, 5);
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("so driven without select");
	property p_so_fall;
		so_oe && $past(so_oe) && $changed(so) |-> fall_cnt_r <= 4'h5;
	endproperty
	a_so_fall: assert property (p_so_fall) else $error("so moved off a fall");
	property p_si_rise;
		$rose(sck) && !cs_n |-> $stable(si);
	endproperty
	a_si_rise: assert property (p_si_rise) else $error("si moved at rise");
	property p_hold_move;
		$changed(hold_n) |-> !sck && !$past(sck);
	endproperty
	a_hold_move: assert property (p_hold_move) else $error("hold moved, clock high");
	property p_half;
		!cs_n && $changed(sck) |=> $stable(sck) [*3];
	endproperty
	a_half: assert property (p_half) else $error("clock half period short");
	property p_reset;
		$fell(i_rst) |-> cs_n && hold_n && !so_oe && so_line;
	endproperty
	a_reset: assert property (p_reset) else $error("link not idle after reset");
endmodule // spi_link_chk
`default_nettype wire

// *** bench/tb.sv ***
// bench: apb controller driving the serial memory over the link
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam int CS = spi_mem_pkg::CTRL_CS_BIT;
	logic        i_ref_clk, i_rst, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, seed, rdat;
	wire  [31:0] prdata;
	wire         pready, pslverr, active;
	wire  [7:0]  status;
	int          failures, compares, i;
	logic [3:0]  ctrl;
	logic [10:0] base;
	logic [7:0]  mem_m [2048];
	logic [33:0] expq [$];
	logic [33:0] ent;
	logic [15:0] atab [7] = '{16'hfffe, 16'hffff, 16'hf800, 16'h03ff, 16'h0400, 16'h05ff, 16'h0600};

	// ==========
	// both ends joined by the link, checker beside it
	spi_link_if link ();
	spi_mem_master spi_mem_master_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(link.master));
	spi_mem_device spi_mem_device_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.link(link.device), .o_status(status), .o_active(active));
	spi_link_chk spi_link_chk_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .cs_n(link.cs_n),
		.sck(link.sck), .si(link.si), .hold_n(link.hold_n), .wp_n(link.wp_n), .so(link.so),
		.so_oe(link.so_oe), .so_line(link.so_line));

	// clock
	initial
	begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// ==========
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [33:0] ex(input logic [7:0] b);
		return {2'b10, 24'h0, b};
	endfunction
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_ref_clk);
		penable <= 1'b1;
		@(posedge i_ref_clk);
		for (n = 0; n < 5000 && pready !== 1'b1; n++)
			@(posedge i_ref_clk);
		if (n == 5000)
		begin
			failures++;
			finish_test;
		end
		rdat = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge i_ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		expq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	// poll status until idle with the given flag up
	task automatic wait_for(input int b);
		int n;
		for (n = 0; n < 500; n++)
		begin
			rd(spi_mem_pkg::REG_STAT, 34'h0);
			if (rdat[0] === 1'b0 && rdat[b] === 1'b1)
				break;
		end
		if (n == 500)
		begin
			failures++;
			finish_test;
		end
	endtask
	task automatic xb(input logic [7:0] b, input logic [7:0] e);
		apb(1'b1, spi_mem_pkg::REG_TX, {24'h0, b});
		wait_for(1);
		rd(spi_mem_pkg::REG_RX, ex(e));
	endtask
	task automatic setc(input int b, input logic v);
		ctrl[b] = v;
		apb(1'b1, spi_mem_pkg::REG_CTRL, {28'h0, ctrl});
	endtask
	task automatic op(input logic [7:0] c, input logic [7:0] v, input logic [7:0] e, input int n);
		setc(CS, 1'b1);
		xb(c, 8'hff);
		if (n > 0)
			xb(v, e);
		setc(CS, 1'b0);
	endtask
	task automatic wmem(input logic [15:0] a, input logic [7:0] d, input logic en, input logic ok);
		if (en)
			op(spi_mem_pkg::CMD_WREN, 8'h0, 8'h0, 0);
		setc(CS, 1'b1);
		xb(spi_mem_pkg::CMD_WRITE, 8'hff);
		xb(a[15:8], 8'hff);
		xb(a[7:0], 8'hff);
		xb(d, 8'hff);
		setc(CS, 1'b0);
		if (ok)
			mem_m[a[10:0]] = d;
	endtask
	task automatic rmem(input logic [15:0] a, input int n);
		setc(CS, 1'b1);
		xb(spi_mem_pkg::CMD_READ, 8'hff);
		xb(a[15:8], 8'hff);
		xb(a[7:0], 8'hff);
		for (int k = 0; k < n; k++)
			xb(8'h00, mem_m[a[10:0] + 11'(k)]);
		setc(CS, 1'b0);
	endtask
	task automatic wsr(input logic [7:0] v);
		op(spi_mem_pkg::CMD_WREN, 8'h0, 8'h0, 0);
		op(spi_mem_pkg::CMD_WR_STAT, v, 8'hff, 1);
	endtask

	// ==========
	// result watcher: oldest note against each read answer
	always @(posedge i_ref_clk)
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
		begin
			ent = expq.pop_front();
			if (ent[33])
				check({pslverr, prdata}, ent[32:0]);
		end

	// ==========
	// main sequence
	initial
	begin
		{i_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{failures, compares, seed, ctrl} = {32'h0, 32'h0, 32'h5a, spi_mem_pkg::CTRL_RESET};
		repeat (4) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		rd(spi_mem_pkg::REG_CTRL, ex(8'h06));
		rd(spi_mem_pkg::REG_STAT, ex(8'h00));
		rd(spi_mem_pkg::REG_TX, ex(8'h00));
		rd(8'h10, {2'b11, 32'h0});
		check({32'h0, link.so_line}, 33'h1);
		check({32'h0, active}, 33'h0);
		$display("test reset done");
		for (i = 0; i < 7; i++)
		begin
			seed = xs(seed);
			wmem(atab[i], seed[7:0], 1'b1, 1'b1);
		end
		rmem(16'h07fe, 3);
		wmem(16'h03ff, 8'h3c, 1'b0, 1'b0);
		op(spi_mem_pkg::CMD_WREN, 8'h0, 8'h0, 0);
		op(spi_mem_pkg::write_disable_command, 8'h0, 8'h0, 0);
		wmem(16'h03ff, 8'hc3, 1'b0, 1'b0);
		rmem(16'h03ff, 1);
		op(8'hab, spi_mem_pkg::CMD_WREN, 8'hff, 1);
		op(spi_mem_pkg::CMD_RD_STAT, 8'h00, 8'h00, 1);
		$display("test write latch done");
		for (i = 1; i < 4; i++)
		begin
			base = (i == 3) ? 11'h000 : 11'(2048 - 512 * i);
			wsr(8'(i << 2));
			seed = xs(seed);
			wmem({5'h0, base}, seed[7:0], 1'b1, 1'b0);
			wmem({5'h0, base - 11'h1}, seed[15:8], 1'b1, i != 3);
			rmem({5'h0, base - 11'h1}, 2);
		end
		wsr(8'h8c);
		setc(spi_mem_pkg::CTRL_WP_BIT, 1'b0);
		wsr(8'h00);
		op(spi_mem_pkg::CMD_RD_STAT, 8'h00, 8'h8c, 1);
		check({25'h0, status}, {25'h0, 8'h8c});
		setc(spi_mem_pkg::CTRL_WP_BIT, 1'b1);
		wsr(8'h00);
		$display("test protection done");
		setc(CS, 1'b1);
		xb(spi_mem_pkg::CMD_READ, 8'hff);
		xb(8'h04, 8'hff);
		xb(8'h00, 8'hff);
		setc(spi_mem_pkg::CTRL_HOLD_BIT, 1'b0);
		xb(8'h00, 8'hff);
		setc(spi_mem_pkg::CTRL_HOLD_BIT, 1'b1);
		xb(8'h00, mem_m[11'h400]);
		setc(CS, 1'b0);
		setc(spi_mem_pkg::CTRL_CPOL_BIT, 1'b1);
		rmem(16'h07fe, 3);
		setc(spi_mem_pkg::CTRL_CPOL_BIT, 1'b0);
		$display("test hold and mode done");
		setc(CS, 1'b1);
		apb(1'b1, spi_mem_pkg::REG_TX, {24'h0, spi_mem_pkg::CMD_READ});
		wait_for(1);
		apb(1'b1, spi_mem_pkg::REG_TX, 32'h0);
		wait_for(2);
		check({32'h0, active}, 33'h1);
		rd(spi_mem_pkg::REG_STAT, ex(8'h06));
		rd(spi_mem_pkg::REG_RX, ex(8'hff));
		rd(spi_mem_pkg::REG_RX, ex(8'hff));
		rd(spi_mem_pkg::REG_RX, ex(8'h00));
		rd(spi_mem_pkg::REG_STAT, ex(8'h00));
		setc(CS, 1'b0);
		$display("test buffer done");
		for (i = 0; i < 3; i++)
		begin
			seed = xs(seed);
			wmem(seed[15:0], seed[23:16], 1'b1, 1'b1);
			rmem(seed[15:0], 1);
		end
		$display("test random done");
		finish_test;
	end
endmodule // tb
`default_nettype wire
